// >>> rtl/timer_pair_map.vh
`ifndef TIMER_PAIR_MAP_VH
`define TIMER_PAIR_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define OFS_RUN        8'h00
`define OFS_MODE       8'h04
`define OFS_LOWER_CMP  8'h08
`define OFS_UPPER_CMP  8'h0C
`define OFS_FF_CTRL    8'h10
`define OFS_STATUS     8'h14
`define OFS_COUNT      8'h18

////////////////////////////////////////////////////////////////////////////////
// run register bits
`define RUN_LOWER_BIT  0
`define RUN_UPPER_BIT  1
`define RUN_DBUF_BIT   7
`define RUN_MASK       8'h83

// mode register field positions (two bits each)
`define MODE_LSEL_LSB  0
`define MODE_USEL_LSB  2
`define MODE_PWM_LSB   4
`define MODE_PAIR_LSB  6

// pair mode codes
`define PAIR_TWO8      2'h0
`define PAIR_CASCADE   2'h1
`define PAIR_PULSE     2'h2
`define PAIR_PWM       2'h3

// pwm cycle codes and their overflow values
`define PWM_N6         2'h1
`define PWM_N7         2'h2
`define PWM_TOP6       8'h3F
`define PWM_TOP7       8'h7F
`define PWM_TOP8       8'hFF

// toggle flip-flop control fields
`define FF_SRC_BIT     0
`define FF_INV_BIT     1
`define FF_CMD_LSB     2
`define FF_CMD_TOGGLE  2'h0
`define FF_CMD_SET     2'h1
`define FF_CMD_CLEAR   2'h2

// status bits
`define STAT_LOWER_BIT 0
`define STAT_UPPER_BIT 1

// reset values
`define RST_BYTE       8'h00

// bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> rtl/edge_sync.v
`timescale 1ns/1ns
`default_nettype none

// brings a pin into the clock domain and flags its rising edges
module edge_sync (
    // clock and reset
    input  wire ref_clk,
    input  wire reset,
    // pin side
    input  wire pinIn,
    // one-cycle pulse per rising edge
    output reg  risePulse_reg
);

    reg syncA_reg;  // first stage, read only by second stage
    reg syncB_reg;  // second stage
    reg last_reg;   // previous synced level

    ////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser and edge detector
    always @(posedge ref_clk) begin
        if (reset) begin
            syncA_reg     <= 1'b0;
            syncB_reg     <= 1'b0;
            last_reg      <= 1'b0;
            risePulse_reg <= 1'b0;
        end else begin
            syncA_reg     <= pinIn;
            syncB_reg     <= syncA_reg;
            last_reg      <= syncB_reg;
            risePulse_reg <= syncB_reg & ~last_reg;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/dual_8bit_timer_pair.v
// Summary of operation
// - two independent 8-bit interval timers in mode 00
// - lower and upper clock source selectors
// - upper counts lower matches when selected
// - run clear stops and zeroes counter
// - selected match toggles flip-flop when enabled
// - mode 01 cascades into 16-bit timer
// - cascade upper clocked by lower overflow
// - lower compare low byte, upper high byte
// - lower write disables, upper write enables compare
// - cascade low match: no clear, no irq
// - cascade full match clears, irq, toggles
// - pulse mode on lower, upper unused
// - pulse output toggles on either compare
// - pulse double buffer loads at upper match
// - waveforms drive the timer output pin
// - pwm on lower, upper stays 8-bit timer
// - pwm toggles at compare and overflow
// - pwm counter clears at overflow
// - pwm compare below overflow, buffer loads
// - mode and pwm cycle field encodings
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timer_pair_map.vh"

module dual_8bit_timer_pair (
    // clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // axi4-lite write address
    input  wire [7:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    // axi4-lite write data
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // axi4-lite write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // axi4-lite read address
    input  wire [7:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    // axi4-lite read data
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // prescaler taps, one-cycle pulses on ref_clk
    input  wire        prescaler_tap_1,
    input  wire        prescaler_tap_4,
    input  wire        prescaler_tap_16,
    input  wire        prescaler_tap_256,
    // external count pin, asynchronous
    input  wire        external_count_input,
    // timer output and interrupt pulses
    output reg         timer_output_pin,
    output reg         lower_match_irq,
    output reg         upper_match_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    reg  [7:0]  run_reg;             // pair_run_reg
    reg  [7:0]  mode_reg;            // pair_mode_reg
    reg  [7:0]  lowerCmp_reg;        // active lower_compare_reg
    reg  [7:0]  lowerBuf_reg;        // lower compare double buffer
    reg  [7:0]  upperCmp_reg;        // upper_compare_reg
    reg  [1:0]  ffCtrl_reg;          // toggle_ff_control_reg stored bits
    reg         cmp16En_reg;         // cascade compare permitted
    reg  [7:0]  lowerCount_reg;      // lower_up_counter
    reg  [7:0]  upperCount_reg;      // upper_up_counter
    reg         lowerFlag_reg;       // sticky lower match status
    reg         upperFlag_reg;       // sticky upper match status
    reg  [7:0]  awAddr_reg;          // held write address
    reg         awHeld_reg;          // write address captured
    reg  [31:0] wData_reg;           // held write data
    reg         wStrb0_reg;          // held low byte lane enable
    reg         wHeld_reg;           // write data captured

    // combinational results
    reg  [7:0]  lowerCount_next;
    reg  [7:0]  upperCount_next;
    reg         lowerMatch;          // lower comparator pulse
    reg         lowerEvent;          // lower interrupt event
    reg         upperEvent;          // upper interrupt event
    reg         ffToggle;            // flip-flop inversion request
    reg         bufLoad;             // move buffer into lower compare
    reg         lowerSrc;            // selected lower clock source
    reg         upperSrc;            // selected upper clock source
    reg  [7:0]  pwmTop;              // pwm overflow value
    reg  [31:0] readMux;             // read data for araddr
    reg         readOk;              // araddr is mapped

    wire        extTick;             // synced external rising edge
    wire [1:0]  pairMode  = mode_reg[`MODE_PAIR_LSB+1:`MODE_PAIR_LSB];
    wire [1:0]  pwmSel    = mode_reg[`MODE_PWM_LSB+1:`MODE_PWM_LSB];
    wire [1:0]  upperSel  = mode_reg[`MODE_USEL_LSB+1:`MODE_USEL_LSB];
    wire [1:0]  lowerSel  = mode_reg[`MODE_LSEL_LSB+1:`MODE_LSEL_LSB];
    wire        lowerRun  = run_reg[`RUN_LOWER_BIT];
    wire        upperRun  = run_reg[`RUN_UPPER_BIT];
    wire        dbufEn    = run_reg[`RUN_DBUF_BIT];
    wire        lowerTick = lowerRun & lowerSrc;
    wire [7:0]  lowInc    = lowerCount_reg + 8'h01;
    wire [7:0]  upInc     = upperCount_reg + 8'h01;
    wire        waveMode  = (pairMode == `PAIR_PULSE) | (pairMode == `PAIR_PWM);

    // bus write strobes
    wire        doWrite   = awHeld_reg & wHeld_reg & ~bvalid;
    wire [7:0]  wrOfs     = awAddr_reg & 8'hFC;
    wire [7:0]  wrByte    = wData_reg[7:0];
    wire        wrMapped  = (wrOfs <= `OFS_COUNT);
    wire        wrLane    = doWrite & wStrb0_reg;
    wire        wrRun     = wrLane & (wrOfs == `OFS_RUN);
    wire        wrMode    = wrLane & (wrOfs == `OFS_MODE);
    wire        wrLowCmp  = wrLane & (wrOfs == `OFS_LOWER_CMP);
    wire        wrUpCmp   = wrLane & (wrOfs == `OFS_UPPER_CMP);
    wire        wrFf      = wrLane & (wrOfs == `OFS_FF_CTRL);
    wire        wrStat    = wrLane & (wrOfs == `OFS_STATUS);
    wire [1:0]  ffCmd     = wrByte[`FF_CMD_LSB+1:`FF_CMD_LSB];

    ////////////////////////////////////////////////////////////////////////////
    // external count pin synchroniser
    edge_sync extSync (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .pinIn         (external_count_input),
        .risePulse_reg (extTick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock source selection and pwm overflow value
    always @* begin
        // lower source: pin or taps 1, 4, 16
        case (lowerSel)
            2'h0:    lowerSrc = extTick;
            2'h1:    lowerSrc = prescaler_tap_1;
            2'h2:    lowerSrc = prescaler_tap_4;
            default: lowerSrc = prescaler_tap_16;
        endcase
        // pwm cycle code to overflow value
        case (pwmSel)
            `PWM_N6: pwmTop = `PWM_TOP6;
            `PWM_N7: pwmTop = `PWM_TOP7;
            default: pwmTop = `PWM_TOP8;                  // 00 reserved, 11 full
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // counters, comparators and events
    always @* begin
        lowerCount_next = lowerCount_reg;
        upperCount_next = upperCount_reg;
        lowerMatch      = 1'b0;
        lowerEvent      = 1'b0;
        upperEvent      = 1'b0;
        ffToggle        = 1'b0;
        bufLoad         = 1'b0;
        upperSrc        = 1'b0;
        case (pairMode)
            `PAIR_CASCADE: begin
                // 16-bit interval timer
                if (lowerTick) begin
                    lowerMatch = (lowInc == lowerCmp_reg);
                    if (lowerMatch && cmp16En_reg && (upperCount_reg == upperCmp_reg)) begin
                        lowerCount_next = 8'h00;
                        upperCount_next = 8'h00;
                        upperEvent      = 1'b1;
                        ffToggle        = 1'b1;
                    end else begin
                        lowerCount_next = lowInc;
                        if (lowerCount_reg == 8'hFF && upperRun) begin
                            upperCount_next = upInc;
                        end
                    end
                end
            end
            `PAIR_PULSE: begin
                // programmable pulse from the lower counter
                upperCount_next = 8'h00;
                if (lowerTick) begin
                    if (lowInc == upperCmp_reg) begin
                        lowerCount_next = 8'h00;
                        ffToggle        = 1'b1;
                        bufLoad         = 1'b1;
                        lowerEvent      = 1'b1;
                    end else begin
                        lowerCount_next = lowInc;
                        if (lowInc == lowerCmp_reg) begin
                            ffToggle = 1'b1;
                        end
                    end
                end
            end
            `PAIR_PWM: begin
                // pwm on the lower counter
                if (lowerTick) begin
                    if (lowInc == pwmTop) begin
                        lowerCount_next = 8'h00;
                        ffToggle        = 1'b1;
                        bufLoad         = 1'b1;
                        lowerEvent      = 1'b1;
                    end else begin
                        lowerCount_next = lowInc;
                        if (lowInc == lowerCmp_reg) begin
                            ffToggle   = 1'b1;
                            lowerMatch = 1'b1;
                        end
                    end
                end
            end
            default: begin
                // two 8-bit interval timers, lower half
                if (lowerTick) begin
                    if (lowInc == lowerCmp_reg) begin
                        lowerCount_next = 8'h00;
                        lowerMatch      = 1'b1;
                        lowerEvent      = 1'b1;
                    end else begin
                        lowerCount_next = lowInc;
                    end
                end
                ffToggle = ffCtrl_reg[`FF_SRC_BIT] ? 1'b0 : lowerEvent;
            end
        endcase
        // upper half as an independent 8-bit timer
        if (pairMode == `PAIR_TWO8 || pairMode == `PAIR_PWM) begin
            case (upperSel)
                2'h0:    upperSrc = lowerMatch;
                2'h1:    upperSrc = prescaler_tap_1;
                2'h2:    upperSrc = prescaler_tap_16;
                default: upperSrc = prescaler_tap_256;
            endcase
            if (upperRun && upperSrc) begin
                if (upInc == upperCmp_reg) begin
                    upperCount_next = 8'h00;
                    upperEvent      = 1'b1;
                end else begin
                    upperCount_next = upInc;
                end
            end
            if (pairMode == `PAIR_TWO8 && ffCtrl_reg[`FF_SRC_BIT]) begin
                ffToggle = upperEvent;
            end
        end
        // a stopped timer holds zero
        if (!lowerRun) begin
            lowerCount_next = 8'h00;
        end
        if (!upperRun) begin
            upperCount_next = 8'h00;
        end
        // inversion must be enabled
        ffToggle = ffToggle & ffCtrl_reg[`FF_INV_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer registers, flip-flop and status
    always @(posedge ref_clk) begin
        if (reset) begin
            run_reg          <= `RST_BYTE;
            mode_reg         <= `RST_BYTE;
            lowerCmp_reg     <= `RST_BYTE;
            lowerBuf_reg     <= `RST_BYTE;
            upperCmp_reg     <= `RST_BYTE;
            ffCtrl_reg       <= 2'h0;
            cmp16En_reg      <= 1'b1;
            lowerCount_reg   <= 8'h00;
            upperCount_reg   <= 8'h00;
            lowerFlag_reg    <= 1'b0;
            upperFlag_reg    <= 1'b0;
            timer_output_pin <= 1'b0;
            lower_match_irq  <= 1'b0;
            upper_match_irq  <= 1'b0;
        end else begin
            lowerCount_reg  <= lowerCount_next;
            upperCount_reg  <= upperCount_next;
            lower_match_irq <= lowerEvent;
            upper_match_irq <= upperEvent;
            // control writes
            if (wrRun) begin
                run_reg <= wrByte & `RUN_MASK;
            end
            if (wrMode) begin
                mode_reg <= wrByte;
            end
            // lower compare goes through the buffer in waveform modes when dbufEn is set
            if (wrLowCmp) begin
                lowerBuf_reg <= wrByte;
                cmp16En_reg  <= 1'b0;
                if (!(dbufEn && waveMode)) begin
                    lowerCmp_reg <= wrByte;
                end
            end else if (bufLoad && dbufEn) begin
                lowerCmp_reg <= lowerBuf_reg;
            end
            if (wrUpCmp) begin
                upperCmp_reg <= wrByte;
                cmp16En_reg  <= 1'b1;
            end
            // flip-flop: software command, else hardware toggle
            if (wrFf) begin
                ffCtrl_reg <= wrByte[1:0];
                case (ffCmd)
                    `FF_CMD_SET:    timer_output_pin <= 1'b1;
                    `FF_CMD_CLEAR:  timer_output_pin <= 1'b0;
                    `FF_CMD_TOGGLE: timer_output_pin <= ~timer_output_pin;
                    default:        timer_output_pin <= timer_output_pin ^ ffToggle;
                endcase
            end else if (ffToggle) begin
                timer_output_pin <= ~timer_output_pin;
            end
            // sticky status, set wins over write-one-clear
            lowerFlag_reg <= lowerEvent |
                             (lowerFlag_reg & ~(wrStat & wrByte[`STAT_LOWER_BIT]));
            upperFlag_reg <= upperEvent |
                             (upperFlag_reg & ~(wrStat & wrByte[`STAT_UPPER_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data mux
    always @* begin
        readMux = 32'h00000000;
        readOk  = 1'b1;
        case (araddr & 8'hFC)
            `OFS_RUN:       readMux[7:0]  = run_reg;
            `OFS_MODE:      readMux[7:0]  = mode_reg;
            `OFS_LOWER_CMP: readMux[7:0]  = lowerCmp_reg;
            `OFS_UPPER_CMP: readMux[7:0]  = upperCmp_reg;
            `OFS_FF_CTRL:   readMux[1:0]  = ffCtrl_reg;
            `OFS_STATUS:    readMux[2:0]  = {timer_output_pin, upperFlag_reg, lowerFlag_reg};
            `OFS_COUNT:     readMux[15:0] = {upperCount_reg, lowerCount_reg};
            default:        readOk        = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channels
    always @(posedge ref_clk) begin
        if (reset) begin
            awready    <= 1'b0;
            wready     <= 1'b0;
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg  <= 32'h00000000;
            wStrb0_reg <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= `RESP_OKAY;
        end else begin
            // address channel
            if (awready && awvalid) begin
                awAddr_reg <= awaddr;
                awHeld_reg <= 1'b1;
                awready    <= 1'b0;
            end else if (!awHeld_reg && !bvalid) begin
                awready <= 1'b1;
            end
            // data channel
            if (wready && wvalid) begin
                wData_reg  <= wdata;
                wStrb0_reg <= wstrb[0];
                wHeld_reg  <= 1'b1;
                wready     <= 1'b0;
            end else if (!wHeld_reg && !bvalid) begin
                wready <= 1'b1;
            end
            // response once both halves are in
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg  <= 1'b0;
                bvalid     <= 1'b1;
                bresp      <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channels
    always @(posedge ref_clk) begin
        if (reset) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else begin
            if (arready && arvalid) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= readMux;
                rresp   <= readOk ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/timer_pair_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// watches bus answers, interrupt pulses and the output pin
module timer_pair_assertions (
    // clock and reset
    input wire        ref_clk, reset,
    // bus handshakes and payloads
    input wire        awvalid, awready, wvalid, wready, bvalid, bready,
    input wire        arvalid, arready, rvalid, rready,
    input wire [1:0]  bresp,
    input wire [31:0] rdata,
    // count sources and outputs
    input wire        prescaler_tap_1, prescaler_tap_4, prescaler_tap_16, prescaler_tap_256,
    input wire        external_count_input,
    input wire        timer_output_pin, lower_match_irq, upper_match_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [3:0] sinceTick_reg;  // cycles since any count source was high
    logic [3:0] sinceWrite_reg; // cycles since a write word was taken
    wire anyTick = prescaler_tap_1 | prescaler_tap_4 | prescaler_tap_16 | prescaler_tap_256
                 | external_count_input;
    // saturating age counters
    always @(posedge ref_clk) begin
        sinceTick_reg <= (reset | anyTick) ? 4'h0 : sinceTick_reg + {3'h0, sinceTick_reg != 4'hF};
        sinceWrite_reg <= (reset | (wvalid & wready)) ? 4'h0
                        : sinceWrite_reg + {3'h0, sinceWrite_reg != 4'hF};
    end
    sequence wrBoth;
        awvalid && awready && wvalid && wready;
    endsequence
    AST_LIRQ_CAUSE: assert property (lower_match_irq |-> sinceTick_reg <= 4'h3)
        else $error("lower irq without a tick");
    AST_UIRQ_CAUSE: assert property (upper_match_irq |-> sinceTick_reg <= 4'h3)
        else $error("upper irq without a tick");
    AST_PIN_CAUSE: assert property ($changed(timer_output_pin) |->
        (sinceTick_reg <= 4'h3 || sinceWrite_reg <= 4'h3))
        else $error("output pin moved without cause");
    AST_B_AFTER: assert property (wrBoth |-> ##[1:2] bvalid)
        else $error("write response late");
    AST_R_AFTER: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AW_REFUSE: assert property (wrBoth |=> !awready && !wready)
        else $error("write accepted twice");
endmodule
bind dual_8bit_timer_pair timer_pair_assertions chk (.*);
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_pair_map.vh"
module tb_top;
    logic        ref_clk = 1'b0, reset = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0]  tapBus = 4'h0;  // tap1, tap4, tap16, tap256 from bit 0
    logic [1:0]  rsp;
    logic        pinLast = 1'b0;
    logic        extPin = 1'b0;  // external count pin
    wire         awready, wready, bvalid, arready, rvalid, pinOut, lowIrq, upIrq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    int lowCount = 0, upCount = 0, flips = 0, baseL, baseU, baseF;
    dual_8bit_timer_pair dut (.ref_clk(ref_clk), .reset(reset), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .prescaler_tap_1(tapBus[0]), .prescaler_tap_4(tapBus[1]),
        .prescaler_tap_16(tapBus[2]), .prescaler_tap_256(tapBus[3]),
        .external_count_input(extPin), .timer_output_pin(pinOut), .lower_match_irq(lowIrq),
        .upper_match_irq(upIrq));
    initial forever #20 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    // event counting and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (lowIrq === 1'b1) lowCount++;
        if (upIrq === 1'b1) upCount++;
        if (!reset && pinOut !== pinLast) flips++;
        pinLast <= pinOut;
        if (cycles == 10000) begin
            n_mismatch++;
            test_done();
        end
    end
    task test_done;
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus write: address and data together, each released when taken
    task wr(input [7:0] a, input [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rdReg(input [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask
    // n single-cycle pulses on the chosen taps, then let events land
    task tick(input [3:0] m, input int n);
        repeat (n) begin
            tapBus <= m;
            @(posedge ref_clk);
            tapBus <= 4'h0;
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask
    task mark;
        baseL = lowCount;
        baseU = upCount;
        baseF = flips;
    endtask
    task deltas(input int dl, input int du, input int df);
        check(lowCount - baseL, dl);
        check(upCount - baseU, du);
        check(flips - baseF, df);
    endtask
    task setup(input [7:0] m, input [7:0] lc, input [7:0] uc);
        wr(`OFS_RUN, 8'h00);
        wr(`OFS_MODE, m);
        wr(`OFS_LOWER_CMP, lc);
        wr(`OFS_UPPER_CMP, uc);
        wr(`OFS_FF_CTRL, 8'h0B);  // upper source, inversion on, cleared
        mark();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task two_timers;
        setup(8'h02, 8'h04, 8'h02);
        wr(`OFS_RUN, 8'h03);
        tick(4'hD, 20);
        deltas(0, 0, 0);
        mark();
        tick(4'h2, 42);
        deltas(10, 5, 5);
        wr(`OFS_RUN, 8'h00);
        rdReg(`OFS_COUNT);
        check(rd, 32'h0);
    endtask
    // lower timer counts rising edges of the external pin
    task ext_pin;
        setup(8'h00, 8'h02, 8'h00);
        wr(`OFS_RUN, 8'h01);
        repeat (4) begin
            extPin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            extPin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        deltas(2, 0, 0);
    endtask
    task cascade;
        setup(8'h41, 8'h02, 8'h01);
        wr(`OFS_RUN, 8'h03);
        tick(4'h1, 258);
        deltas(0, 1, 1);
        wr(`OFS_LOWER_CMP, 8'h02);
        mark();
        tick(4'h1, 258);
        deltas(0, 0, 0);
    endtask
    task pwm_modes;
        for (int k = 1; k < 4; k++) begin
            setup({2'b11, k[1:0], 4'b0011}, 8'h0A, 8'h02);
            wr(`OFS_RUN, 8'h03);
            tick(4'h4, ((1 << (k + 5)) - 1) * 2);
            deltas(2, 1, 4);
        end
    endtask
    task pulse_gen;
        setup(8'h81, 8'h0A, 8'h28);
        wr(`OFS_RUN, 8'h83);
        tick(4'h1, 80);
        deltas(2, 0, 4);
        wr(`OFS_LOWER_CMP, 8'h05);
        rdReg(`OFS_LOWER_CMP);
        check(rd, 32'h0A);
        tick(4'h1, 40);
        rdReg(`OFS_LOWER_CMP);
        check(rd, 32'h05);
        rdReg(8'h20);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
        wr(8'h20, 8'h00);
        check({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        two_timers();
        ext_pin();
        cascade();
        pwm_modes();
        pulse_gen();
        test_done();
    end
endmodule
`default_nettype wire
